// File: inc/sahi_map.vh
// Constants for the converter control and readout block.
// Assumes a single 40 MHz clock and an AXI4-Lite register port.
// What this block does
// - Stand-alone mode starts a conversion on a falling read/convert line.
// - Stand-alone outputs drive only while read/convert is high and status is low.
// - A low pulse floats outputs at once; they return after the conversion ends.
// - A high pulse shows the old result; its falling edge starts a new one.
// - Byte select is captured at start; high means eight bits, low twelve.
// - After an eight-bit conversion the four lowest result bits read zero.
// - Byte select is latched and the mode input is sampled at start; other controls act combinationally.
// - Conversion starts when the last of enable, select, read/convert qualifies.
// - Status is high only while a conversion runs.
// - Data outputs float throughout a conversion.
// - Start inputs are ignored during a conversion.
// - A later start transition latches the new byte select value.
// - Full control drives outputs when read high, status low, enabled, selected.
// - Width select high drives all twelve bits and ignores byte select.
// - Width low, byte low drives result bits 11 to 4 on outputs 7 to 0.
// - Width low, byte high drives bits 3 to 0 high and zeros below.
// - Byte select may toggle freely; the two bytes never drive together.
// - Control mode holds and converts at once on the command.
// - Emulation mode waits an acquisition delay of 1.6 us before converting.
// - Sampling resumes tracking as soon as a conversion completes.
// - Status falls on the same edge that latches the result into the data register.
// - The mode input low selects emulation, high selects control mode.
`ifndef SAHI_MAP_VH
`define SAHI_MAP_VH
`define SAHI_CLK_MHZ        40
`define SAHI_APERTURE_NS    1600
`define SAHI_APERTURE_CYC   ((`SAHI_APERTURE_NS * `SAHI_CLK_MHZ) / 1000)
`define SAHI_BIT_CYC        20
`define SAHI_REG_CTRL       12'h000
`define SAHI_REG_STAT       12'h004
`define SAHI_REG_RESULT     12'h008
`define SAHI_REG_SAMPLE     12'h00c
`define SAHI_CTRL_FULL_BIT  0
`define SAHI_CTRL_RESET     32'h00000001
`endif

// File: logic/sahi_core.v
// Converter control, readout and a small AXI4-Lite register port.
// Assumes all pin inputs are synchronous to aclk; the bench resolves the tristate bus.
`timescale 1ns/1ps
`include "sahi_map.vh"
module sahi_core #(
  parameter integer BIT_CYC      = `SAHI_BIT_CYC,
  parameter integer APERTURE_CYC = `SAHI_APERTURE_CYC
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Converter control pins
  input  wire        chip_enable,
  input  wire        chip_select_n,
  input  wire        read_convert_n,
  input  wire        byte_select,
  input  wire        width_select,
  input  wire        mode_select_input,
  // Comparator decision from the analog side
  input  wire        comparator_in,
  // Converter outputs
  output reg         status,
  output reg         sample_hold,
  output reg  [11:0] result_out_bits,
  output reg  [11:0] result_out_oe,
  // AXI4-Lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ACQ  = 2'd1;
  localparam [1:0] ST_CONV = 2'd2;
  localparam [1:0] ST_DONE = 2'd3;

  // Full reset word of the control register; only its mode bit is kept in a flop.
  localparam [31:0] CTRL_RESET = `SAHI_CTRL_RESET;

  reg  [1:0]  state_reg;
  reg  [10:0] cnt_reg;
  reg  [3:0]  bit_reg;
  reg  [11:0] sar_reg;
  reg  [11:0] data_reg;
  reg         short_reg;
  reg         short_data_reg;
  reg         qual_reg;
  reg         full_ctrl_reg;
  reg  [15:0] conv_count_reg;
  reg         aw_got_reg;
  reg         w_got_reg;
  reg  [11:0] aw_addr_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  // Start is qualified by all three control inputs; stand-alone mode forces the
  // enable and select terms so that only the read/convert line counts.
  wire ce_eff   = full_ctrl_reg ? chip_enable : 1'b1;
  wire cs_eff   = full_ctrl_reg ? ~chip_select_n : 1'b1;
  wire qual_now = ce_eff & cs_eff & ~read_convert_n;
  wire start    = qual_now & ~qual_reg & (state_reg == ST_IDLE);
  wire busy     = (state_reg != ST_IDLE);

  // Position of the last bit decision depends on the latched length.
  wire [3:0] last_bit = short_reg ? 4'd4 : 4'd0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= 11'd0;
      bit_reg        <= 4'd11;
      sar_reg        <= 12'h000;
      data_reg       <= 12'h000;
      short_reg      <= 1'b0;
      short_data_reg <= 1'b0;
      qual_reg       <= 1'b0;
      conv_count_reg <= 16'h0000;
      status         <= 1'b0;
      sample_hold    <= 1'b0;
    end else begin
      qual_reg <= qual_now;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            short_reg <= byte_select;
            status    <= 1'b1;
            cnt_reg   <= 11'd0;
            bit_reg   <= 4'd11;
            sar_reg   <= 12'h800;
            if (!mode_select_input) begin
              state_reg <= ST_ACQ;
            end else begin
              sample_hold <= 1'b1;
              state_reg   <= ST_CONV;
            end
          end
        end
        ST_ACQ: begin
          if (cnt_reg == APERTURE_CYC[10:0] - 11'd1) begin
            cnt_reg     <= 11'd0;
            sample_hold <= 1'b1;
            state_reg   <= ST_CONV;
          end else begin
            cnt_reg <= cnt_reg + 11'd1;
          end
        end
        ST_CONV: begin
          if (cnt_reg == BIT_CYC[10:0] - 11'd1) begin
            cnt_reg <= 11'd0;
            // Keep or drop the trial bit, then try the next one down.
            if (!comparator_in) begin
              sar_reg[bit_reg] <= 1'b0;
            end
            if (bit_reg == last_bit) begin
              sample_hold <= 1'b0;
              state_reg   <= ST_DONE;
            end else begin
              sar_reg[bit_reg - 4'd1] <= 1'b1;
              bit_reg <= bit_reg - 4'd1;
            end
          end else begin
            cnt_reg <= cnt_reg + 11'd1;
          end
        end
        ST_DONE: begin
          // Result latched here; status falls on the same edge.
          data_reg       <= short_reg ? {sar_reg[11:4], 4'h0} : sar_reg;
          short_data_reg <= short_reg;
          conv_count_reg <= conv_count_reg + 16'h0001;
          status         <= 1'b0;
          state_reg      <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Output enable is decoded combinationally from the live pins and a registered
  // status, then registered with the data so both pins move on the same edge.
  // Because the byte lanes are chosen by a single select, they cannot overlap.
  wire        rd_ok = read_convert_n & ~busy & ~status & ce_eff & cs_eff;
  reg  [11:0] oe_next;
  reg  [11:0] out_next;
  always @* begin
    oe_next  = 12'h000;
    out_next = 12'h000;
    if (rd_ok) begin
      if (width_select || !full_ctrl_reg) begin
        oe_next  = 12'hfff;
        out_next = data_reg;
      end else if (!byte_select) begin
        oe_next  = 12'h0ff;
        out_next = {4'h0, data_reg[11:4]};
      end else begin
        oe_next  = 12'h0ff;
        out_next = {4'h0, data_reg[3:0], 4'h0};
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      result_out_oe   <= 12'h000;
      result_out_bits <= 12'h000;
    end else begin
      result_out_oe   <= start ? 12'h000 : oe_next;
      result_out_bits <= out_next;
    end
  end

  // Register port: one write and one read at a time, answered one cycle
  // after both address and data are held.
  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      full_ctrl_reg <= CTRL_RESET[`SAHI_CTRL_FULL_BIT];
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg[11:2] == `SAHI_REG_CTRL >> 2) begin
          s_axi_bresp <= 2'b00;
          if (w_strb_reg[0]) begin
            full_ctrl_reg <= w_data_reg[`SAHI_CTRL_FULL_BIT];
          end
        end else if (aw_addr_reg[11:2] <= `SAHI_REG_SAMPLE >> 2) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr[11:2])
          `SAHI_REG_CTRL >> 2:   s_axi_rdata <= {31'd0, full_ctrl_reg};
          `SAHI_REG_STAT >> 2:   s_axi_rdata <= {28'd0, short_data_reg, mode_select_input,
                                                 sample_hold, status};
          `SAHI_REG_RESULT >> 2: s_axi_rdata <= {20'd0, data_reg};
          `SAHI_REG_SAMPLE >> 2: s_axi_rdata <= {16'd0, conv_count_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sahi_core

// File: dv/sahi_core_properties.sv
// Checker for the converter pins of the core.
// Assumes it is bound to the core and sees only its ports.
`timescale 1ns/1ps
module sahi_core_properties (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Pins
  input wire        chip_enable,
  input wire        chip_select_n,
  input wire        read_convert_n,
  input wire        mode_select_input,
  input wire        status,
  input wire        sample_hold,
  input wire [11:0] result_out_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_cmd;
    !status && chip_enable && !chip_select_n && !read_convert_n && $past(read_convert_n);
  endsequence
  property p_start; s_cmd |=> status; endproperty
  property p_busy; status |-> result_out_oe == 12'h000; endproperty
  property p_oe; |result_out_oe |-> $past(read_convert_n) && !$past(status); endproperty
  property p_shape; result_out_oe inside {12'h000, 12'h0ff, 12'hfff}; endproperty
  property p_len; $rose(status) |-> status [*8]; endproperty
  property p_ctl; $rose(status) && mode_select_input |-> ##[0:1] sample_hold; endproperty
  property p_emu; $rose(status) && !mode_select_input |-> !sample_hold; endproperty
  property p_track; $fell(status) |-> !sample_hold; endproperty
  a_start: assert property (p_start) else $error("no start on command");
  a_busy: assert property (p_busy) else $error("outputs driven while busy");
  a_oe: assert property (p_oe) else $error("outputs driven without read");
  a_shape: assert property (p_shape) else $error("bytes driven together");
  a_len: assert property (p_len) else $error("conversion cut short");
  a_ctl: assert property (p_ctl) else $error("no hold on command");
  a_emu: assert property (p_emu) else $error("hold before delay");
  a_track: assert property (p_track) else $error("not tracking at end");
endmodule // sahi_core_properties

// File: dv/sahi_host_bus.sv
// Host side view of the three-state result lines.
// Assumes one clock shared with the core.
`timescale 1ns/1ps
module sahi_host_bus (
  // Clock
  input wire         aclk,
  // Core outputs
  input wire  [11:0] bits,
  input wire  [11:0] oe,
  // Resolved lines
  output wire [11:0] bus
);
  logic [11:0] pat = 12'h5a5;
  // A floating line must never look like held data, so it toggles each cycle.
  always @(posedge aclk) pat <= ~pat;
  assign bus = (bits & oe) | (pat & ~oe);
endmodule // sahi_host_bus

// File: dv/sar_adc_host_interface_test.sv
// Bench for the core: pin reads, conversions and register port.
// Assumes a constant comparator level, so results are all ones or zeros.
`timescale 1ns/1ps
`include "sahi_map.vh"
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module sar_adc_host_interface_test;
  logic        aclk = 0, aresetn = 0, ce = 1, cs_n = 0, rc_n = 1, a0 = 0, wsel = 1, mode = 1;
  logic        cmp = 1, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  wire         awready, wready, bvalid, arready, rvalid, status, sh;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [11:0] bits, oe, bus;
  int          error_cnt = 0, tests_run = 0, i;
  sahi_core #(.BIT_CYC(2), .APERTURE_CYC(2)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .chip_enable(ce), .chip_select_n(cs_n),
    .read_convert_n(rc_n), .byte_select(a0), .width_select(wsel),
    .mode_select_input(mode), .comparator_in(cmp), .status(status), .sample_hold(sh),
    .result_out_bits(bits), .result_out_oe(oe), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
  sahi_host_bus u_bus (.aclk(aclk), .bits(bits), .oe(oe), .bus(bus));
  initial forever #12.5 aclk = ~aclk;
  task finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 200) begin error_cnt++; $display("[ERR] wait exp done got timeout"); finish_test; end
  endtask
  task axw(input [11:0] a, input [31:0] d);
    bit aw, w;
    aw = 0; w = 0;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    for (i = 0; i < 200 && !(aw && w); i++) begin
      @(posedge aclk);
      if (awready === 1) begin aw = 1; awvalid <= 0; end
      if (wready === 1) begin w = 1; wvalid <= 0; end
    end
    tmo(i);
    for (i = 0; i < 200 && bvalid !== 1; i++) @(posedge aclk);
    tmo(i);
    `CHK("bresp", 2'b00, bresp)
  endtask
  task axr(input [11:0] a, input [1:0] er, input [31:0] ed);
    arvalid <= 1; araddr <= a;
    for (i = 0; i < 200; i++) begin @(posedge aclk); if (arready === 1) break; end
    tmo(i);
    arvalid <= 0;
    for (i = 0; i < 200; i++) begin @(posedge aclk); if (rvalid === 1) break; end
    tmo(i);
    `CHK("rresp", er, rresp)
    `CHK("rdata", ed, rdata)
  endtask
  task idle;
    for (i = 0; i < 200 && status !== 1; i++) @(posedge aclk);
    for (; i < 200 && status !== 0; i++) @(posedge aclk);
    tmo(i);
  endtask
  // The restart attempt toggles the command line while busy; it must be ignored.
  task conv(input b, input c, input up);
    a0 <= b; cmp <= c; rc_n <= 0;
    repeat (2) @(posedge aclk);
    a0 <= ~b;
    if (up) begin rc_n <= 1; @(posedge aclk); rc_n <= 0; @(posedge aclk); rc_n <= 1; end
    idle;
  endtask
  task pins(input w, input b, input [11:0] eoe, input [11:0] ed);
    wsel <= w; a0 <= b; rc_n <= 1;
    repeat (2) @(posedge aclk);
    `CHK("oe", eoe, oe)
    `CHK("bus", ed, bus & oe)
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    axr(`SAHI_REG_CTRL, 2'b00, `SAHI_CTRL_RESET);
    axr(12'h100, 2'b10, 32'h0);
    $display("Test registers done");
    conv(0, 1, 0);
    pins(1, 1, 12'hfff, 12'hfff);
    pins(0, 0, 12'h0ff, 12'h0ff);
    pins(0, 1, 12'h0ff, 12'h0f0);
    axr(`SAHI_REG_RESULT, 2'b00, 32'hfff);
    conv(1, 1, 1);
    pins(1, 0, 12'hfff, 12'hff0);
    conv(0, 0, 1);
    pins(1, 1, 12'hfff, 12'h000);
    $display("Test full control done");
    ce <= 0; rc_n <= 0; a0 <= 0; cmp <= 1;
    repeat (3) @(posedge aclk);
    ce <= 1;
    idle;
    cs_n <= 1;
    pins(1, 0, 12'h000, 12'h000);
    cs_n <= 0;
    pins(1, 0, 12'hfff, 12'hfff);
    $display("Test enable start done");
    axw(`SAHI_REG_CTRL, 32'h0);
    mode <= 0;
    conv(0, 1, 1);
    pins(0, 1, 12'hfff, 12'hfff);
    conv(1, 0, 0);
    pins(1, 0, 12'hfff, 12'h000);
    axr(`SAHI_REG_SAMPLE, 2'b00, 32'h6);
    $display("Test stand-alone done");
    finish_test;
  end
endmodule // sar_adc_host_interface_test
bind sahi_core sahi_core_properties u_chk (
  .aclk(aclk), .aresetn(aresetn), .chip_enable(chip_enable), .chip_select_n(chip_select_n),
  .read_convert_n(read_convert_n), .mode_select_input(mode_select_input),
  .status(status), .sample_hold(sample_hold), .result_out_oe(result_out_oe));
